// ---- rtl/srsb_exec.sv ----
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module srsb_exec
	import srsb_pkg::*;
#(
	parameter int DATA_W = 32,
	parameter int ADDR_W = 8
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR_STROBE,
	input wire logic RD_STROBE,
	output logic [31:0] RDATA,
	output logic STORE_REQ,
	output logic [31:0] STORE_ADDR,
	output logic [7:0] STORE_BYTE,
	input wire logic STORE_DONE,
	input wire logic STORE_ALIGN_FAULT,
	output logic BUSY,
	output logic IRQ
);
	import srsb_pkg::*;

	// ==========================================================
	// Elaboration checks
	if (DATA_W != 32) begin : g_data_w
		$error("Only 32-bit data is supported");
	end
	if (ADDR_W < 8) begin : g_addr_w
		$error("Address must be at least 8 bits");
	end

	// ==========================================================
	// Helpers
	function automatic srsb_op_t decode(input logic [31:0] ins);
		srsb_op_t k;
		k = OP_BAD;
		if (ins[31:26] == OPC_STORE_D)
			k = OP_STORE_D;
		else if (ins[31:26] == OPC_STORE_DU)
			k = OP_STORE_DU;
		else if (ins[31:26] == OPC_EXT && ins[10:1] == XOP_SHIFT)
			k = OP_SHIFT;
		else if (ins[31:26] == OPC_EXT && ins[10:1] == XOP_STORE_XU)
			k = OP_STORE_XU;
		return k;
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		return a == ADDR_W'(ofs);
	endfunction

	function automatic logic is_store(input srsb_op_t k);
		return k == OP_STORE_D || k == OP_STORE_DU || k == OP_STORE_XU;
	endfunction

	// ==========================================================
	// State
	srsb_state_t state;
	srsb_state_t next_state;
	logic [31:0] gpr [32];
	logic [31:0] instr;
	logic [4:0] gpr_sel;
	logic [3:0] cond;
	logic xer_so;
	logic [EV_W-1:0] status;
	logic [EV_W-1:0] enable;
	logic [EV_W-1:0] ev_set;
	logic [EV_W-1:0] ev_clr;
	logic [EV_W-1:0] next_status;
	logic [31:0] last_addr;
	logic [31:0] count;
	logic [4:0] upd_reg;
	logic upd_pending;

	// ==========================================================
	// Operand fetch and address arithmetic
	srsb_op_t op;
	logic [4:0] fld_src;
	logic [4:0] fld_base;
	logic [4:0] fld_idx;
	logic rec;
	logic [31:0] src_val;
	logic [31:0] base_val;
	logic [31:0] idx_val;
	logic [31:0] disp;
	logic [31:0] effective_addr;
	logic [31:0] shift_res;

	assign op = decode(instr);
	assign fld_src = instr[25:21];
	assign fld_base = instr[20:16];
	assign fld_idx = instr[15:11];
	assign rec = instr[0];
	assign src_val = gpr[fld_src];
	assign base_val = (fld_base == 5'h00) ? 32'h0000_0000 : gpr[fld_base];
	assign idx_val = gpr[fld_idx];
	assign disp = {{16{instr[15]}}, instr[15:0]};

	always_comb begin
		if (op == OP_STORE_XU)
			effective_addr = base_val + idx_val;
		else
			effective_addr = base_val + disp;
	end

	srsb_shifter u_shift (
		.src(src_val),
		.amount(idx_val[5:0]),
		.result(shift_res)
	);

	// ==========================================================
	// Sequencer
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (WR_STROBE && hit(ADDR, OFS_INSTR))
					next_state = ST_EXEC;
			end
			ST_EXEC: begin
				if (op == OP_SHIFT || op == OP_BAD)
					next_state = ST_IDLE;
				else
					next_state = ST_STORE;
			end
			ST_STORE: begin
				if (STORE_DONE)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			BUSY <= 1'b0;
		else
			BUSY <= (next_state != ST_IDLE);
	end

	// ==========================================================
	// Instruction and selector registers
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			instr <= RST_WORD;
			gpr_sel <= 5'h00;
		end else begin
			if (state == ST_IDLE && WR_STROBE && hit(ADDR, OFS_INSTR))
				instr <= WDATA;
			if (WR_STROBE && hit(ADDR, OFS_GPR_SEL))
				gpr_sel <= WDATA[4:0];
		end
	end

	// ==========================================================
	// General purpose registers
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			for (int i = 0; i < 32; i++)
				gpr[i] <= RST_WORD;
		end else if (state == ST_EXEC && op == OP_SHIFT) begin
			gpr[fld_base] <= shift_res;
		end else if (state == ST_STORE && STORE_DONE) begin
			if (upd_pending && !STORE_ALIGN_FAULT)
				gpr[upd_reg] <= last_addr;
		end else if (state == ST_IDLE && WR_STROBE && hit(ADDR, OFS_GPR_DATA)) begin
			gpr[gpr_sel] <= WDATA;
		end
	end

	// ==========================================================
	// Condition field and exception register
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			cond <= RST_COND;
		end else if (state == ST_EXEC && op == OP_SHIFT && rec) begin
			cond[COND_NEG] <= shift_res[31];
			cond[COND_POS] <= !shift_res[31] && (shift_res != 32'h0000_0000);
			cond[COND_ZERO] <= (shift_res == 32'h0000_0000);
			cond[COND_SO] <= xer_so;
		end else if (state == ST_IDLE && WR_STROBE && hit(ADDR, OFS_COND)) begin
			cond <= WDATA[3:0];
		end
	end

	// Only software writes it; no instruction here touches it
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			xer_so <= 1'b0;
		else if (WR_STROBE && hit(ADDR, OFS_XER))
			xer_so <= WDATA[0];
	end

	// ==========================================================
	// Storage port
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			STORE_REQ <= 1'b0;
			STORE_ADDR <= RST_WORD;
			STORE_BYTE <= 8'h00;
			upd_pending <= 1'b0;
			upd_reg <= 5'h00;
		end else if (state == ST_EXEC && is_store(op)) begin
			STORE_REQ <= 1'b1;
			STORE_ADDR <= effective_addr;
			STORE_BYTE <= src_val[7:0];
			upd_pending <= (op != OP_STORE_D) && (fld_base != 5'h00);
			upd_reg <= fld_base;
		end else begin
			STORE_REQ <= 1'b0;
			if (state == ST_STORE && STORE_DONE)
				upd_pending <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			last_addr <= RST_WORD;
		else if (state == ST_EXEC && is_store(op))
			last_addr <= effective_addr;
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			count <= RST_WORD;
		else if (state == ST_EXEC && op != OP_BAD)
			count <= count + 32'h0000_0001;
	end

	// ==========================================================
	// Events and interrupt
	always_comb begin
		ev_set = RST_EVENTS;
		ev_set[EV_DONE] = (state == ST_EXEC && op == OP_SHIFT) || (state == ST_STORE && STORE_DONE);
		ev_set[EV_ILLEGAL] = (state == ST_EXEC && op == OP_BAD);
		ev_set[EV_ALIGN] = (state == ST_STORE && STORE_DONE && STORE_ALIGN_FAULT);
		ev_clr = (WR_STROBE && hit(ADDR, OFS_CLEAR)) ? WDATA[EV_W-1:0] : RST_EVENTS;
		next_status = (status & ~ev_clr) | ev_set;
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			status <= RST_EVENTS;
		else
			status <= next_status;
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			enable <= RST_EVENTS;
		else if (WR_STROBE && hit(ADDR, OFS_ENABLE))
			enable <= WDATA[EV_W-1:0];
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			IRQ <= 1'b0;
		else
			IRQ <= |(status & enable);
	end

	// ==========================================================
	// Read port
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			RDATA <= RST_WORD;
		end else if (RD_STROBE) begin
			RDATA <= RST_WORD;
			if (hit(ADDR, OFS_INSTR))
				RDATA <= instr;
			else if (hit(ADDR, OFS_GPR_SEL))
				RDATA <= {27'h0, gpr_sel};
			else if (hit(ADDR, OFS_GPR_DATA))
				RDATA <= gpr[gpr_sel];
			else if (hit(ADDR, OFS_COND))
				RDATA <= {28'h0, cond};
			else if (hit(ADDR, OFS_XER))
				RDATA <= {31'h0, xer_so};
			else if (hit(ADDR, OFS_STATUS))
				RDATA <= {29'h0, status};
			else if (hit(ADDR, OFS_ENABLE))
				RDATA <= {29'h0, enable};
			else if (hit(ADDR, OFS_STATE))
				RDATA <= {30'h0, state};
			else if (hit(ADDR, OFS_LAST_ADDR))
				RDATA <= last_addr;
			else if (hit(ADDR, OFS_COUNT))
				RDATA <= count;
		end else begin
			RDATA <= RST_WORD;
		end
	end

endmodule

// ---- rtl/srsb_pkg.sv ----
// Operation
// - Shift right word: N from amount bits 27-31, rotate left 32-N, mask, write target
// - Amount bit 26 clear: mask is N zeros then 32-N ones
// - Amount bit 26 set: mask all zeros, target receives zero
// - Decode opcode 31, extended 536; fields at 6-10, 11-15, 16-20, record bit 31
// - Record bit set updates condition field 0; clear leaves it unchanged
// - Shift right word never changes the exception register
// - Displacement address is base plus sign-extended 16-bit displacement, or displacement alone
// - Opcode 39 stores byte, then writes address to nonzero base unless alignment fault
// - Opcode 31 extended 247: address is base plus index, or index alone
// - Indexed update writes address to base only if base nonzero and no fault
// - Byte stores leave exception register and condition field 0 unchanged
package srsb_pkg;

	// ==========================================================
	// Instruction encoding
	localparam logic [5:0] OPC_EXT = 6'h1f;
	localparam logic [5:0] OPC_STORE_D = 6'h26;
	localparam logic [5:0] OPC_STORE_DU = 6'h27;
	localparam logic [9:0] XOP_SHIFT = 10'h218;
	localparam logic [9:0] XOP_STORE_XU = 10'h0f7;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_GPR_SEL = 8'h04;
	localparam logic [7:0] OFS_GPR_DATA = 8'h08;
	localparam logic [7:0] OFS_COND = 8'h0c;
	localparam logic [7:0] OFS_XER = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_CLEAR = 8'h18;
	localparam logic [7:0] OFS_ENABLE = 8'h1c;
	localparam logic [7:0] OFS_STATE = 8'h20;
	localparam logic [7:0] OFS_LAST_ADDR = 8'h24;
	localparam logic [7:0] OFS_COUNT = 8'h28;

	// ==========================================================
	// Field positions
	localparam int COND_NEG = 3;
	localparam int COND_POS = 2;
	localparam int COND_ZERO = 1;
	localparam int COND_SO = 0;
	localparam int EV_DONE = 0;
	localparam int EV_ILLEGAL = 1;
	localparam int EV_ALIGN = 2;
	localparam int EV_W = 3;

	// ==========================================================
	// Reset values
	localparam logic [3:0] RST_COND = 4'h0;
	localparam logic [EV_W-1:0] RST_EVENTS = 3'h0;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_STORE = 2'b10
	} srsb_state_t;

	typedef enum logic [2:0] {
		OP_SHIFT = 3'b000,
		OP_STORE_D = 3'b001,
		OP_STORE_DU = 3'b010,
		OP_STORE_XU = 3'b011,
		OP_BAD = 3'b100
	} srsb_op_t;

endpackage

// ---- rtl/srsb_shifter.sv ----
`timescale 1ns/1ps
module srsb_shifter (
	input wire logic [31:0] src,
	input wire logic [5:0] amount,
	output logic [31:0] result
);
	logic [4:0] n;
	logic [63:0] doubled;
	logic [31:0] rotated;
	logic [31:0] mask;

	assign n = amount[4:0];
	assign doubled = {src, src};
	// Rotate left by 32 minus N equals rotate right by N
	assign rotated = doubled[n +: 32];
	assign mask = amount[5] ? 32'h0000_0000 : (32'hffff_ffff >> n);
	assign result = rotated & mask;
endmodule

// ---- verif/srsb_exec_properties.sv ----
`timescale 1ns/1ps
module srsb_exec_properties
	import srsb_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR_STROBE,
	input wire logic RD_STROBE,
	input wire logic [31:0] RDATA,
	input wire logic STORE_REQ,
	input wire logic [31:0] STORE_ADDR,
	input wire logic [7:0] STORE_BYTE,
	input wire logic STORE_DONE,
	input wire logic STORE_ALIGN_FAULT,
	input wire logic BUSY,
	input wire logic IRQ
);
	// ==========
	// Properties
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	logic go;
	logic [5:0] opc;
	assign go = WR_STROBE && ADDR == OFS_INSTR && !BUSY;
	assign opc = WDATA[31:26];
	a_shift_decode: assert property (go && opc == OPC_EXT && WDATA[10:1] == XOP_SHIFT
		|=> BUSY ##1 !BUSY && !STORE_REQ) else $error("shift timing wrong");
	a_store_issue: assert property (go && (opc == OPC_STORE_D || opc == OPC_STORE_DU ||
		(opc == OPC_EXT && WDATA[10:1] == XOP_STORE_XU)) |=> BUSY && !STORE_REQ ##1 STORE_REQ)
		else $error("store not issued");
	a_bad_op: assert property (go && opc == 6'h00 |=> !STORE_REQ [*3])
		else $error("store from bad opcode");
	a_addr_direct: assert property (go && opc == OPC_STORE_D && WDATA[20:16] == 5'h00
		|=> ##1 STORE_ADDR == {{16{$past(WDATA[15], 2)}}, $past(WDATA[15:0], 2)})
		else $error("address not displacement");
	a_req_pulse: assert property (STORE_REQ |=> !STORE_REQ)
		else $error("store request too long");
	a_store_hold: assert property (!STORE_REQ |-> $stable(STORE_ADDR) && $stable(STORE_BYTE))
		else $error("store data moved");
	a_busy_release: assert property (BUSY && STORE_DONE |=> !BUSY)
		else $error("busy after store done");
	a_req_busy: assert property (STORE_REQ |-> BUSY)
		else $error("store while idle");
endmodule
bind srsb_exec srsb_exec_properties #(.ADDR_W(ADDR_W)) u_srsb_exec_properties (.CLK_SYS(CLK_SYS),
	.RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR_STROBE(WR_STROBE), .RD_STROBE(RD_STROBE),
	.RDATA(RDATA), .STORE_REQ(STORE_REQ), .STORE_ADDR(STORE_ADDR), .STORE_BYTE(STORE_BYTE),
	.STORE_DONE(STORE_DONE), .STORE_ALIGN_FAULT(STORE_ALIGN_FAULT), .BUSY(BUSY), .IRQ(IRQ));

// ---- verif/srsb_mem_model.sv ----
`timescale 1ns/1ps
module srsb_mem_model (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic store_req,
	input wire logic [31:0] store_addr,
	input wire logic [7:0] store_byte,
	input wire logic [3:0] lat,
	input wire logic fault,
	output logic store_done,
	output logic store_align_fault,
	output logic [31:0] got_addr,
	output logic [7:0] got_byte
);
	// ==========
	// Storage side
	logic pend;
	logic [3:0] cnt;
	always_ff @(posedge clk_sys) begin
		store_done <= 1'b0;
		store_align_fault <= ~store_align_fault;
		if (reset) begin
			pend <= 1'b0;
			store_align_fault <= 1'b0;
		end else if (store_req) begin
			pend <= 1'b1;
			cnt <= lat;
			got_addr <= store_addr;
			got_byte <= store_byte;
		end else if (pend && cnt == 4'h0) begin
			pend <= 1'b0;
			store_done <= 1'b1;
			store_align_fault <= fault;
		end else if (pend) begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule

// ---- verif/tb_srsb_exec.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module tb_srsb_exec;
	import srsb_pkg::*;
	logic clk_sys, reset, wr_strobe, rd_strobe, store_req, store_done, store_align_fault;
	logic busy, irq, fault;
	logic [7:0] addr, store_byte, got_byte;
	logic [31:0] wdata, rdata, store_addr, got_addr, v, e;
	logic [3:0] lat;
	int err_total, checked;
	logic [31:0] src_t [6] = '{32'hb004_3001, 32'h9000_3000, 32'h8000_0000, 32'h1234_5678,
		32'hb004_3001, 32'h1};
	logic [31:0] amt_t [6] = '{32'h4, 32'h24, 32'h1f, 32'h0, 32'h0, 32'h20};
	logic [31:0] res_t [6] = '{32'h0b00_4300, 32'h0, 32'h1, 32'h1234_5678, 32'hb004_3001,
		32'h0};
	srsb_exec u_srsb_exec (.CLK_SYS(clk_sys), .RESET(reset), .ADDR(addr), .WDATA(wdata),
		.WR_STROBE(wr_strobe), .RD_STROBE(rd_strobe), .RDATA(rdata), .STORE_REQ(store_req),
		.STORE_ADDR(store_addr), .STORE_BYTE(store_byte), .STORE_DONE(store_done),
		.STORE_ALIGN_FAULT(store_align_fault), .BUSY(busy), .IRQ(irq));
	srsb_mem_model u_srsb_mem_model (.clk_sys(clk_sys), .reset(reset), .store_req(store_req),
		.store_addr(store_addr), .store_byte(store_byte), .lat(lat), .fault(fault),
		.store_done(store_done), .store_align_fault(store_align_fault), .got_addr(got_addr),
		.got_byte(got_byte));
	// ==========
	// Access tasks
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr_strobe <= 1'b1;
		@(posedge clk_sys);
		wr_strobe <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk_sys);
		addr <= a;
		rd_strobe <= 1'b1;
		@(posedge clk_sys);
		rd_strobe <= 1'b0;
		#1 v = rdata;
		`CHK("reg", x, v)
	endtask
	task setg(input logic [4:0] n, input logic [31:0] d);
		wr(OFS_GPR_SEL, {27'h0, n});
		wr(OFS_GPR_DATA, d);
	endtask
	task gchk(input logic [4:0] n, input logic [31:0] x);
		wr(OFS_GPR_SEL, {27'h0, n});
		rchk(OFS_GPR_DATA, x);
	endtask
	task exec(input logic [31:0] i);
		wr(OFS_INSTR, i);
		#1;
		for (int k = 0; k < 40 && busy !== 1'b0; k++) begin
			@(posedge clk_sys);
			#1;
		end
		`CHK("busy", 1'b0, busy)
	endtask
	task st(input logic [31:0] i, input logic f, input logic [3:0] l, input logic [31:0] xa,
		input logic [4:0] bf, input logic [31:0] be);
		fault <= f;
		lat <= l;
		exec(i);
		`CHK("addr", xa, got_addr)
		`CHK("byte", 8'h60, got_byte)
		gchk(bf, be);
	endtask
	function automatic logic [31:0] xf(logic [5:0] o, logic [4:0] s, logic [4:0] a,
		logic [4:0] b, logic [9:0] x, logic r);
		return {o, s, a, b, x, r};
	endfunction
	task wrap_up();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ==========
	// Tests
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		err_total++;
		wrap_up();
	end
	initial begin
		{reset, wr_strobe, rd_strobe, fault, lat, addr, wdata} = {1'b1, 47'h0};
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		rchk(OFS_STATUS, 32'h0);
		rchk(8'h3c, 32'h0);
		$display("reset test done");
		wr(OFS_XER, 32'h1);
		foreach (src_t[k]) begin
			setg(5'd4, src_t[k]);
			setg(5'd5, amt_t[k]);
			exec(xf(OPC_EXT, 5'd4, 5'd6, 5'd5, XOP_SHIFT, 1'b1));
			e = res_t[k];
			gchk(5'd6, e);
			rchk(OFS_COND, {28'h0, $signed(e) < 0, $signed(e) > 0, e == 0, 1'b1});
			rchk(OFS_XER, 32'h1);
		end
		wr(OFS_COND, 32'h9);
		setg(5'd5, 32'h8);
		exec(xf(OPC_EXT, 5'd4, 5'd6, 5'd5, XOP_SHIFT, 1'b0));
		gchk(5'd6, 32'h0000_0000);
		rchk(OFS_COND, 32'h9);
		$display("shift test done");
		setg(5'd6, 32'h0000_0060);
		setg(5'd4, 32'h1000);
		setg(5'd5, 32'h20);
		st({OPC_STORE_D, 5'd6, 5'd4, 16'hfff0}, 1'b0, 4'h0, 32'h0ff0, 5'd4, 32'h1000);
		st({OPC_STORE_D, 5'd6, 5'd0, 16'h8000}, 1'b0, 4'h2, 32'hffff_8000, 5'd0, 32'h0);
		st({OPC_STORE_DU, 5'd6, 5'd4, 16'h10}, 1'b0, 4'h3, 32'h1010, 5'd4, 32'h1010);
		st({OPC_STORE_DU, 5'd6, 5'd4, 16'h10}, 1'b1, 4'h1, 32'h1020, 5'd4, 32'h1010);
		st({OPC_STORE_DU, 5'd6, 5'd0, 16'h44}, 1'b0, 4'h0, 32'h44, 5'd0, 32'h0);
		e = xf(OPC_EXT, 5'd6, 5'd4, 5'd5, XOP_STORE_XU, 1'b0);
		st(e, 1'b0, 4'h0, 32'h1030, 5'd4, 32'h1030);
		st(e, 1'b1, 4'h4, 32'h1050, 5'd4, 32'h1030);
		e = xf(OPC_EXT, 5'd6, 5'd0, 5'd5, XOP_STORE_XU, 1'b0);
		st(e, 1'b0, 4'h0, 32'h20, 5'd0, 32'h0);
		rchk(OFS_COND, 32'h9);
		rchk(OFS_XER, 32'h1);
		rchk(OFS_LAST_ADDR, 32'h20);
		$display("store test done");
		rchk(OFS_STATUS, 32'h5);
		wr(OFS_ENABLE, 32'h4);
		repeat (2) @(posedge clk_sys);
		#1 `CHK("irq", 1'b1, irq)
		wr(OFS_CLEAR, 32'h7);
		exec(32'h0);
		rchk(OFS_STATUS, 32'h2);
		`CHK("irq", 1'b0, irq)
		rchk(OFS_COUNT, 32'hf);
		wr(OFS_ENABLE, 32'h2);
		repeat (2) @(posedge clk_sys);
		#1 `CHK("irq", 1'b1, irq)
		$display("interrupt test done");
		wrap_up();
	end
endmodule
